// ==== hdl/irq_control_register.sv ====
// interrupt control register with apb slave access
`timescale 1ns/10ps
`include "irq_cfg.svh"

module irq_control_register (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        clk_en,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [`IRQ_ADDR_W-1:0]      paddr,
  input  wire logic [31:0]                 pwdata,
  input  wire logic [3:0]                  pstrb,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire irq_pkg::src_events_t        src_events,
  input  wire logic [`IRQ_BANK_W-1:0]      pin_change_flag_bank,
  input  wire logic                        periph_irq_pending,
  output irq_pkg::irq_ctrl_t               irq_control_reg,
  output logic                             core_irq
);

  // register select codes
  localparam logic [1:0] SEL_NONE = 2'h0;
  localparam logic [1:0] SEL_CTRL = 2'h1;
  localparam logic [1:0] SEL_STAT = 2'h2;

  function automatic logic [1:0] reg_select(input logic [`IRQ_ADDR_W-1:0] addr);
    logic [1:0] sel;
    sel = SEL_NONE;
    case (addr)
      `IRQ_CTRL_OFFSET: begin
        sel = SEL_CTRL;
      end
      `IRQ_STAT_OFFSET: begin
        sel = SEL_STAT;
      end
      default: begin
        sel = SEL_NONE;
      end
    endcase
    return sel;
  endfunction

  function automatic irq_pkg::qphase_t next_phase(input irq_pkg::qphase_t ph);
    irq_pkg::qphase_t nx;
    nx = irq_pkg::PH_Q1;
    case (ph)
      irq_pkg::PH_Q1: begin
        nx = irq_pkg::PH_Q2;
      end
      irq_pkg::PH_Q2: begin
        nx = irq_pkg::PH_Q3;
      end
      irq_pkg::PH_Q3: begin
        nx = irq_pkg::PH_Q4;
      end
      irq_pkg::PH_Q4: begin
        nx = irq_pkg::PH_Q1;
      end
      default: begin
        nx = irq_pkg::PH_Q1;
      end
    endcase
    return nx;
  endfunction

  // external flag may only set in the fourth and first quarter phases
  function automatic logic in_ext_window(input irq_pkg::qphase_t ph);
    logic ok;
    ok = 1'b0;
    case (ph)
      irq_pkg::PH_Q4: begin
        ok = 1'b1;
      end
      irq_pkg::PH_Q1: begin
        ok = 1'b1;
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction

  // a source counts only with its flag and its enable both set
  function automatic logic gated(input logic flag, input logic en);
    return flag && en;
  endfunction

  // software write of enable and flag bits; bit 0 is read-only
  function automatic irq_pkg::irq_ctrl_t write_ctrl(input irq_pkg::irq_ctrl_t cur,
                                                    input logic [31:0]      wdata);
    irq_pkg::irq_ctrl_t nx;
    nx                           = cur;
    nx.global_irq_enable         = wdata[`IRQ_BIT_GLOBAL_EN];
    nx.periph_group_enable       = wdata[`IRQ_BIT_PERIPH_EN];
    nx.timer_overflow_irq_enable = wdata[`IRQ_BIT_TMR_IE];
    nx.ext_pin_irq_enable        = wdata[`IRQ_BIT_EXT_IE];
    nx.pin_change_irq_enable     = wdata[`IRQ_BIT_PC_IE];
    nx.timer_overflow_flag       = wdata[`IRQ_BIT_TMR_F];
    nx.ext_pin_event_flag        = wdata[`IRQ_BIT_EXT_F];
    return nx;
  endfunction

  // status word as software reads it
  function automatic logic [31:0] status_word(input logic             core,
                                              input logic             tmr,
                                              input logic             ext,
                                              input logic             pc,
                                              input logic             periph,
                                              input logic             waiting,
                                              input irq_pkg::qphase_t ph);
    logic [31:0] w;
    w                                           = 32'h0000_0000;
    w[`IRQ_STAT_CORE]                           = core;
    w[`IRQ_STAT_TMR_PEND]                       = tmr;
    w[`IRQ_STAT_EXT_PEND]                       = ext;
    w[`IRQ_STAT_PC_PEND]                        = pc;
    w[`IRQ_STAT_PERIPH]                         = periph;
    w[`IRQ_STAT_EXT_WAIT]                       = waiting;
    w[`IRQ_STAT_PHASE_LSB +: `IRQ_STAT_PHASE_W] = ph;
    return w;
  endfunction

  // state
  irq_pkg::irq_ctrl_t ctrl_q;
  irq_pkg::irq_ctrl_t ctrl_d;
  irq_pkg::qphase_t   phase_q;
  irq_pkg::qphase_t   phase_d;
  logic               ext_wait_q;
  logic               ext_wait_d;
  logic               core_irq_q;
  logic               core_irq_d;
  logic [31:0]        prdata_q;
  logic [31:0]        prdata_d;
  logic               pslverr_q;
  logic               pslverr_d;

  // decode
  logic [1:0]         sel;
  logic               setup_phase;
  logic               ctrl_wr;
  logic               ext_window;
  logic               ext_set;
  logic               tmr_pend;
  logic               ext_pend;
  logic               pc_pend;
  logic               periph_pend;
  logic [31:0]        stat_word;

  // zero wait states; a frozen block holds the bus in its access phase
  assign pready          = clk_en;
  assign prdata          = prdata_q;
  assign pslverr         = pslverr_q;
  assign irq_control_reg = ctrl_q;
  assign core_irq        = core_irq_q;

  assign sel         = reg_select(paddr);
  assign setup_phase = psel && !penable;
  assign ctrl_wr     = psel && penable && pwrite && (sel == SEL_CTRL) && pstrb[0];

  // external flag window spans the fourth and first quarter phases
  assign ext_window = in_ext_window(phase_q);
  assign ext_set    = (src_events.ext_pin || ext_wait_q) && ext_window;

  // per-source pending terms
  assign tmr_pend    = gated(ctrl_q.timer_overflow_flag,
                             ctrl_q.timer_overflow_irq_enable);
  assign ext_pend    = gated(ctrl_q.ext_pin_event_flag,
                             ctrl_q.ext_pin_irq_enable);
  assign pc_pend     = gated(ctrl_q.pin_change_summary_flag,
                             ctrl_q.pin_change_irq_enable);
  assign periph_pend = gated(periph_irq_pending,
                             ctrl_q.periph_group_enable);

  assign stat_word = status_word(core_irq_q, tmr_pend, ext_pend, pc_pend, periph_pend,
                                 ext_wait_q, phase_q);

  // quarter phase sequencer
  always_comb begin
    phase_d = next_phase(phase_q);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q <= irq_pkg::PH_Q1;
    end else if (clk_en) begin
      phase_q <= phase_d;
    end
  end

  // external event held until its setting window opens
  always_comb begin
    ext_wait_d = ext_wait_q;
    if (ext_set) begin
      ext_wait_d = 1'b0;
    end else if (src_events.ext_pin) begin
      ext_wait_d = 1'b1;
    end
  end

  // control and flag bits; hardware set wins over a software clear
  always_comb begin
    ctrl_d = ctrl_q;
    if (ctrl_wr) begin
      ctrl_d = write_ctrl(ctrl_q, pwdata);
    end
    if (src_events.timer_overflow) begin
      ctrl_d.timer_overflow_flag = 1'b1;
    end
    if (ext_set) begin
      ctrl_d.ext_pin_event_flag = 1'b1;
    end
    // summary follows the bank, writes cannot touch it
    ctrl_d.pin_change_summary_flag = |pin_change_flag_bank;
  end

  // core request, one cycle behind the flags
  always_comb begin
    core_irq_d = ctrl_q.global_irq_enable && (tmr_pend || ext_pend || pc_pend || periph_pend);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= `IRQ_CTRL_RESET;
    end else if (clk_en) begin
      ctrl_q <= ctrl_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_wait_q <= 1'b0;
    end else if (clk_en) begin
      ext_wait_q <= ext_wait_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_irq_q <= 1'b0;
    end else if (clk_en) begin
      core_irq_q <= core_irq_d;
    end
  end

  // read data captured in the setup cycle
  always_comb begin
    prdata_d = prdata_q;
    if (setup_phase) begin
      case (sel)
        SEL_CTRL: begin
          prdata_d = {24'h00_0000, ctrl_q};
        end
        SEL_STAT: begin
          prdata_d = stat_word;
        end
        default: begin
          prdata_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h0000_0000;
    end else if (clk_en) begin
      prdata_q <= prdata_d;
    end
  end

  // unmapped addresses answer with an error
  always_comb begin
    pslverr_d = pslverr_q;
    if (setup_phase) begin
      pslverr_d = (sel == SEL_NONE);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pslverr_q <= 1'b0;
    end else if (clk_en) begin
      pslverr_q <= pslverr_d;
    end
  end

endmodule

// ==== hdl/irq_cfg.svh ====
// offsets, field positions, reset values and timing counts of the interrupt control block
`ifndef IRQ_CFG_SVH
`define IRQ_CFG_SVH

`define IRQ_CTRL_OFFSET      12'h000
`define IRQ_STAT_OFFSET      12'h004
`define IRQ_ADDR_W           12

`define IRQ_CTRL_RESET       8'h00
`define IRQ_CTRL_WR_MASK     8'hfe

`define IRQ_BIT_GLOBAL_EN    7
`define IRQ_BIT_PERIPH_EN    6
`define IRQ_BIT_TMR_IE       5
`define IRQ_BIT_EXT_IE       4
`define IRQ_BIT_PC_IE        3
`define IRQ_BIT_TMR_F        2
`define IRQ_BIT_EXT_F        1
`define IRQ_BIT_PC_F         0

`define IRQ_STAT_CORE        0
`define IRQ_STAT_TMR_PEND    1
`define IRQ_STAT_EXT_PEND    2
`define IRQ_STAT_PC_PEND     3
`define IRQ_STAT_PERIPH      4
`define IRQ_STAT_EXT_WAIT    5
`define IRQ_STAT_PHASE_LSB   8
`define IRQ_STAT_PHASE_W     4

`define IRQ_BANK_W           8
`define IRQ_PHASES_PER_INSN  4

`endif

// ==== hdl/irq_pkg.sv ====
// types shared by the interrupt control block
package irq_pkg;

  typedef struct packed {
    logic global_irq_enable;
    logic periph_group_enable;
    logic timer_overflow_irq_enable;
    logic ext_pin_irq_enable;
    logic pin_change_irq_enable;
    logic timer_overflow_flag;
    logic ext_pin_event_flag;
    logic pin_change_summary_flag;
  } irq_ctrl_t;

  typedef struct packed {
    logic timer_overflow;
    logic ext_pin;
  } src_events_t;

  typedef enum logic [3:0] {
    PH_Q1 = 4'b0001,
    PH_Q2 = 4'b0010,
    PH_Q3 = 4'b0100,
    PH_Q4 = 4'b1000
  } qphase_t;

endpackage

// ==== dv/irq_control_register_monitor.sv ====
// concurrent checks on the interrupt control register ports
`timescale 1ns/10ps
`include "irq_cfg.svh"
module irq_control_register_monitor (
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic                   clk_en,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [`IRQ_ADDR_W-1:0] paddr,
  input wire logic [31:0]            pwdata,
  input wire logic [3:0]             pstrb,
  input wire irq_pkg::src_events_t   src_events,
  input wire logic [`IRQ_BANK_W-1:0] pin_change_flag_bank,
  input wire logic                   periph_irq_pending,
  input wire irq_pkg::irq_ctrl_t     irq_control_reg,
  input wire logic                   core_irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic pend;
  irq_pkg::irq_ctrl_t r;
  assign r = irq_control_reg;
  assign pend = r.timer_overflow_flag & r.timer_overflow_irq_enable
    | r.ext_pin_event_flag & r.ext_pin_irq_enable
    | r.pin_change_summary_flag & r.pin_change_irq_enable
    | r.periph_group_enable & periph_irq_pending;
  sequence ctrl_wr;
    psel && !penable && pwrite && paddr == 12'h000 && pstrb[0] && clk_en ##1 psel && penable && clk_en;
  endsequence
  tmr_flag_set_a: assert property (
    src_events.timer_overflow && clk_en |=> r.timer_overflow_flag) else $error("timer flag missed");
  ext_flag_set_a: assert property (
    src_events.ext_pin && clk_en |-> ##[1:4] r.ext_pin_event_flag) else $error("ext flag missed");
  pc_summary_a: assert property (
    $past(clk_en) |-> r.pin_change_summary_flag == $past(|pin_change_flag_bank))
    else $error("pin-change summary wrong");
  enable_write_a: assert property (
    ctrl_wr |=> r[7:3] == $past(pwdata[7:3])) else $error("enable bits not written");
  tmr_clear_a: assert property (
    ctrl_wr ##0 !pwdata[2] && !src_events.timer_overflow |=> !r.timer_overflow_flag)
    else $error("timer flag not cleared");
  gie_gate_a: assert property (
    core_irq |-> $past(r.global_irq_enable)) else $error("request without global enable");
  src_gate_a: assert property (
    core_irq |-> $past(pend)) else $error("request without enabled source");
  core_req_a: assert property (
    r.global_irq_enable && pend && clk_en |=> core_irq) else $error("request not raised");
endmodule
bind irq_control_register irq_control_register_monitor i_mon (.pclk, .presetn, .clk_en, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .src_events, .pin_change_flag_bank,
  .periph_irq_pending, .irq_control_reg, .core_irq);

// ==== dv/tb_irq_control_register.sv ====
// self-checking bench for the interrupt control register
`timescale 1ns/10ps
module tb_irq_control_register;
  logic                 pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0;
  logic                 periph = 0, pready, pslverr, core_irq;
  logic [11:0]          paddr = 12'h000;
  logic [31:0]          pwdata = 32'h0, prdata, e, m;
  logic [3:0]           pstrb = 4'hf;
  logic [7:0]           bank = 8'h00;
  logic [32:0]          ex, got;
  logic [32:0]          expq[$];
  logic [31:0]          mq[$];
  irq_pkg::src_events_t ev = '0;
  irq_pkg::irq_ctrl_t   ctrl;
  int                   bad_count = 0, check_count = 0, cyc = 0;
  always #50 pclk = ~pclk;
  irq_control_register i_irq_control_register (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite,
    .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .src_events(ev),
    .pin_change_flag_bank(bank), .periph_irq_pending(periph), .irq_control_reg(ctrl), .core_irq);
  task stop_test;
    if (bad_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] x, input logic [31:0] mk);
    expq.push_back(x);
    mq.push_back(mk);
    apb(0, a, 32'h0);
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (psel && penable && pready && !pwrite) begin
      ex = expq.pop_front();
      m = mq.pop_front();
      got = {pslverr, prdata & m};
      check_count++;
      if (got !== ex) begin
        bad_count++;
        $display("Error at %0t: got %h expected %h", $time, got, ex);
      end
    end
    if (cyc == 2000) begin
      bad_count++;
      stop_test;
    end
  end
  initial begin
    void'($urandom(32'h0be9));
    repeat (2) @(posedge pclk);
    presetn <= 1;
    rd(12'h000, 33'h0, 32'hff);
    rd(12'h008, 33'h100000000, 32'hffffffff);
    apb(1, 12'h000, 32'hff);
    rd(12'h000, 33'hfe, 32'hff);
    repeat (8) begin
      e = $urandom;
      bank <= 8'($urandom);
      periph <= 1'($urandom);
      apb(1, 12'h000, {24'h0, e[7:3], 3'b000});
      ev <= 2'b11;
      @(posedge pclk);
      ev <= 2'b00;
      repeat (6) @(posedge pclk);
      rd(12'h000, {25'h0, e[7:3], 2'b11, |bank}, 32'hff);
      rd(12'h004, {27'h0, e[6] & periph, e[3] & |bank, e[4], e[5],
        e[7] & (e[6] & periph | e[3] & |bank | e[4] | e[5])}, 32'h1f);
      bank <= 8'h00;
      apb(1, 12'h000, {24'h0, e[7:3], 3'b000});
      repeat (2) @(posedge pclk);
      rd(12'h000, {25'h0, e[7:3], 3'b000}, 32'hff);
      clk_en <= 1'b0;
      ev     <= 2'b10;
      @(posedge pclk);
      ev     <= 2'b00;
      repeat (2) @(posedge pclk);
      clk_en <= 1'b1;
      rd(12'h000, {25'h0, e[7:3], 3'b000}, 32'hff);
    end
    stop_test;
  end
endmodule
